// ===== common/rhp_pkg.sv
`default_nettype none
// ************************************************************
// constants of the root hub power registers
// ************************************************************
package rhp_pkg;
	// command codes, bit 7 marks a write
	localparam logic [7:0] CMD_RD_DESC_A = 8'h12;
	localparam logic [7:0] CMD_WR_DESC_A = 8'h92;
	localparam logic [7:0] CMD_RD_DESC_B = 8'h13;
	localparam logic [7:0] CMD_WR_DESC_B = 8'h93;
	localparam logic [7:0] CMD_RD_STATUS = 8'h14;
	localparam logic [7:0] CMD_WR_STATUS = 8'h94;
	localparam int         CMD_WRITE_BIT = 7;
	// first descriptor fields
	localparam int DA_POTPGT_LSB = 24;
	localparam int DA_NOCP       = 12;
	localparam int DA_OCPM       = 11;
	localparam int DA_NPS        = 9;
	localparam int DA_PSM        = 8;
	// second descriptor fields
	localparam int DB_PORT_POWER_CONTROL_MASK_LSB = 16;
	localparam int DB_DR_LSB   = 0;
	// hub status fields
	localparam int ST_CRWE = 31;
	localparam int ST_CCIC = 17;
	localparam int ST_GLOBAL_SET_POWER = 16;
	localparam int ST_DRWE = 15;
	localparam int ST_LPS  = 0;
	// limits and values after reset
	localparam int         MAX_PORTS    = 2;
	localparam logic [7:0] POTPGT_RESET = 8'hff;
	localparam logic       NOCP_RESET   = 1'b0;
	localparam logic       OCPM_RESET   = 1'b1;
	localparam logic       NPS_RESET    = 1'b0;
	localparam logic       PSM_RESET    = 1'b1;
	localparam logic [1:0] PORT_POWER_CONTROL_MASK_RESET   = 2'h0;
	localparam logic [1:0] DR_RESET     = 2'h0;
endpackage : rhp_pkg
`default_nettype wire

// ===== hw/rhp_change_det.sv
`default_nettype none
// ************************************************************
// level change detector
// ************************************************************
module rhp_change_det
	import rhp_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic level,
	output logic      changed
);
	typedef struct packed {
		logic prev;
		logic pulse;
	} rhp_det_state_t;

	rhp_det_state_t state_reg;
	rhp_det_state_t state_next;

	// pulse one cycle after the level flips
	always_comb
	begin
		state_next.prev = level;
		state_next.pulse = level ^ state_reg.prev;
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign changed = state_reg.pulse;
endmodule : rhp_change_det
`default_nettype wire

// ===== hw/rhp_port_power.sv
`default_nettype none
// ************************************************************
// power switch of one downstream port
// ************************************************************
module rhp_port_power
	import rhp_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic no_power_switching,
	input  wire logic switching_mode_sel,
	input  wire logic mask,
	input  wire logic glob_set,
	input  wire logic glob_clr,
	input  wire logic port_set,
	input  wire logic port_clr,
	output logic      power
);
	typedef struct packed {
		logic power;
	} rhp_cell_state_t;

	rhp_cell_state_t state_reg;
	rhp_cell_state_t state_next;
	logic            per_port;

	// port follows its own commands only when masked in per-port mode
	assign per_port = switching_mode_sel && mask;

	// next power state, clear beats set in one command
	always_comb
	begin
		state_next = state_reg;
		if (no_power_switching)
			state_next.power = 1'b1;
		else if (per_port)
		begin
			if (port_clr)
				state_next.power = 1'b0;
			else if (port_set)
				state_next.power = 1'b1;
		end
		else
		begin
			if (glob_clr)
				state_next.power = 1'b0;
			else if (glob_set)
				state_next.power = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign power = state_reg.power;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_nps_on;
		no_power_switching |=> power;
	endproperty
	a_nps_on: assert property (p_nps_on) else $error("port unpowered under no switching");

	property p_masked_holds;
		!no_power_switching && per_port && !port_set && !port_clr |=> $stable(power);
	endproperty
	a_masked_holds: assert property (p_masked_holds) else $error("masked port moved");

	property p_unmasked_holds;
		!no_power_switching && !per_port && !glob_set && !glob_clr |=> $stable(power);
	endproperty
	a_unmasked_holds: assert property (p_unmasked_holds) else $error("port cmd moved port");

	property p_global_set;
		!no_power_switching && !per_port && glob_set && !glob_clr |=> power;
	endproperty
	a_global_set: assert property (p_global_set) else $error("global set missed");
endmodule : rhp_port_power
`default_nettype wire

// ===== hw/rhp_regs.sv
`default_nettype none
// ************************************************************
// root hub power descriptor and status registers
// ************************************************************
module rhp_regs
	import rhp_pkg::*;
#(
	parameter int NUM_PORTS = 2
)
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 cmd_valid,
	input  wire logic [7:0]           cmd_code,
	input  wire logic [31:0]          cmd_wdata,
	input  wire logic                 over_current,
	input  wire logic [NUM_PORTS-1:0] port_set_power,
	input  wire logic [NUM_PORTS-1:0] port_clear_power,
	output logic                      rsp_valid,
	output logic [31:0]               rsp_rdata,
	output logic                      cmd_unknown,
	output logic [NUM_PORTS-1:0]      port_power,
	output logic                      remote_wakeup_en
);
	// ************************************************************
	// parameter check
	// ************************************************************
	// count limited
	if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS)
	begin : g_bad_ports
		$error("NUM_PORTS must be 1 or 2");
	end

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [7:0]           potpgt;
		logic                 nocp;
		logic                 ocpm;
		logic                 no_power_switching;
		logic                 switching_mode_sel;
		logic [NUM_PORTS-1:0] port_power_control_mask;
		logic [NUM_PORTS-1:0] dr;
		logic                 drwe;
		logic                 ccic;
		logic                 rsp_valid;
		logic [31:0]          rsp_rdata;
		logic                 cmd_unknown;
	} rhp_regs_state_t;

	rhp_regs_state_t state_reg;
	rhp_regs_state_t state_next;

	logic        wr_a;
	logic        wr_b;
	logic        wr_st;
	logic        glob_set;
	logic        glob_clr;
	logic        oci_rep;
	logic        oci_chg;
	logic [1:0]  downstream_port_count;
	logic [31:0] desc_a_word;
	logic [31:0] desc_b_word;
	logic [31:0] status_word;

	// ************************************************************
	// helpers
	// ************************************************************
	// command hit on the current cycle
	function automatic logic hit(input logic v, input logic [7:0] code,
		input logic [7:0] want);
		hit = v && (code == want);
	endfunction : hit

	// place port bits at field bit 1 upward, bit 0 stays zero
	function automatic logic [31:0] place(input logic [NUM_PORTS-1:0] v);
		place = '0;
		for (int p = 0; p < NUM_PORTS; p++)
			place[p+1] = v[p];
	endfunction : place

	// pull port bits out of a written field
	function automatic logic [NUM_PORTS-1:0] pick(input logic [31:0] w, input int lsb);
		pick = '0;
		for (int p = 0; p < NUM_PORTS; p++)
			pick[p] = w[lsb+p+1];
	endfunction : pick

	// ************************************************************
	// command decode
	// ************************************************************
	// write strobes
	assign wr_a = hit(cmd_valid, cmd_code, CMD_WR_DESC_A);
	assign wr_b = hit(cmd_valid, cmd_code, CMD_WR_DESC_B);
	assign wr_st = hit(cmd_valid, cmd_code, CMD_WR_STATUS);

	// global power strobes from the status write
	assign glob_set = wr_st && cmd_wdata[ST_GLOBAL_SET_POWER];
	assign glob_clr = wr_st && cmd_wdata[ST_LPS];

	// overcurrent shows only with global reporting
	assign oci_rep = over_current && !state_reg.nocp && !state_reg.ocpm;

	assign downstream_port_count = 2'(NUM_PORTS);

	// ************************************************************
	// read words
	// ************************************************************
	// reserved zero, type bit zero
	assign desc_a_word = {state_reg.potpgt, 11'h000, state_reg.nocp, state_reg.ocpm,
		1'b0, state_reg.no_power_switching, state_reg.switching_mode_sel, 6'h00, downstream_port_count};
	assign desc_b_word = (place(state_reg.port_power_control_mask) << DB_PORT_POWER_CONTROL_MASK_LSB)
		| (place(state_reg.dr) << DB_DR_LSB);
	assign status_word = {14'h0000, state_reg.ccic, 1'b0, state_reg.drwe,
		13'h0000, oci_rep, 1'b0};

	// ************************************************************
	// overcurrent change detect
	// ************************************************************
	rhp_change_det u_oci_det (
		.clk     (clk),
		.rst_n   (rst_n),
		.level   (oci_rep),
		.changed (oci_chg)
	);

	// ************************************************************
	// register update and answer
	// ************************************************************
	always_comb
	begin
		state_next = state_reg;
		// first descriptor write, count and type read only
		if (wr_a)
		begin
			state_next.potpgt = cmd_wdata[DA_POTPGT_LSB +: 8];
			state_next.nocp = cmd_wdata[DA_NOCP];
			state_next.ocpm = cmd_wdata[DA_OCPM];
			state_next.no_power_switching = cmd_wdata[DA_NPS];
			state_next.switching_mode_sel = cmd_wdata[DA_PSM];
		end
		if (wr_b)
		begin
			state_next.port_power_control_mask = pick(cmd_wdata, DB_PORT_POWER_CONTROL_MASK_LSB);
			state_next.dr = pick(cmd_wdata, DB_DR_LSB);
		end
		// wake enable, set beats clear
		if (wr_st && cmd_wdata[ST_DRWE])
			state_next.drwe = 1'b1;
		else if (wr_st && cmd_wdata[ST_CRWE])
			state_next.drwe = 1'b0;
		// change flag, hardware set beats write clear
		if (oci_chg)
			state_next.ccic = 1'b1;
		else if (wr_st && cmd_wdata[ST_CCIC])
			state_next.ccic = 1'b0;
		// answer one cycle after each command
		state_next.rsp_valid = cmd_valid;
		state_next.cmd_unknown = 1'b0;
		state_next.rsp_rdata = '0;
		if (cmd_valid)
		begin
			unique case (cmd_code)
				CMD_RD_DESC_A: state_next.rsp_rdata = desc_a_word;
				CMD_RD_DESC_B: state_next.rsp_rdata = desc_b_word;
				CMD_RD_STATUS: state_next.rsp_rdata = status_word;
				CMD_WR_DESC_A, CMD_WR_DESC_B, CMD_WR_STATUS: ;
				default: state_next.cmd_unknown = 1'b1;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
			state_reg.potpgt <= POTPGT_RESET;
			state_reg.nocp <= NOCP_RESET;
			state_reg.ocpm <= OCPM_RESET;
			state_reg.no_power_switching <= NPS_RESET;
			state_reg.switching_mode_sel <= PSM_RESET;
			state_reg.port_power_control_mask <= PORT_POWER_CONTROL_MASK_RESET[NUM_PORTS-1:0];
			state_reg.dr <= DR_RESET[NUM_PORTS-1:0];
		end
		else
			state_reg <= state_next;
	end

	assign rsp_valid = state_reg.rsp_valid;
	assign rsp_rdata = state_reg.rsp_rdata;
	assign cmd_unknown = state_reg.cmd_unknown;
	assign remote_wakeup_en = state_reg.drwe;

	// ************************************************************
	// port power switches
	// ************************************************************
	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_port
		rhp_port_power u_pwr (
			.clk      (clk),
			.rst_n    (rst_n),
			.no_power_switching      (state_reg.no_power_switching),
			.switching_mode_sel      (state_reg.switching_mode_sel),
			.mask     (state_reg.port_power_control_mask[p]),
			.glob_set (glob_set),
			.glob_clr (glob_clr),
			.port_set (port_set_power[p]),
			.port_clr (port_clear_power[p]),
			.power    (port_power[p])
		);
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_read_a;
		cmd_valid && cmd_code == CMD_RD_DESC_A;
	endsequence
	sequence s_read_b;
		cmd_valid && cmd_code == CMD_RD_DESC_B;
	endsequence
	sequence s_read_st;
		cmd_valid && cmd_code == CMD_RD_STATUS;
	endsequence
	sequence s_write_b;
		wr_b;
	endsequence
	sequence s_oci_flip;
		$changed(oci_rep);
	endsequence

	property p_ndp;
		s_read_a |=> rsp_valid && rsp_rdata[1:0] == downstream_port_count
			&& rsp_rdata[10] == 1'b0 && rsp_rdata[7:2] == 6'h00;
	endproperty
	a_ndp: assert property (p_ndp) else $error("port count read wrong");

	property p_read_b;
		s_read_b |=> rsp_rdata == (place($past(state_reg.port_power_control_mask)) << DB_PORT_POWER_CONTROL_MASK_LSB
			| place($past(state_reg.dr)));
	endproperty
	a_read_b: assert property (p_read_b) else $error("second descriptor read wrong");

	property p_read_st;
		s_read_st |=> rsp_rdata[ST_GLOBAL_SET_POWER] == 1'b0 && rsp_rdata[ST_LPS] == 1'b0
			&& rsp_rdata[31:18] == 14'h0000 && rsp_rdata[14:2] == 13'h0000
			&& rsp_rdata[ST_CCIC] == $past(state_reg.ccic);
	endproperty
	a_read_st: assert property (p_read_st) else $error("status read wrong");

	property p_write_b;
		s_write_b |=> state_reg.port_power_control_mask == pick($past(cmd_wdata), DB_PORT_POWER_CONTROL_MASK_LSB)
			&& state_reg.dr == pick($past(cmd_wdata), DB_DR_LSB);
	endproperty
	a_write_b: assert property (p_write_b) else $error("second descriptor write lost");

	property p_glob_clr;
		!state_reg.no_power_switching && !state_reg.switching_mode_sel && glob_clr |=> port_power == '0;
	endproperty
	a_glob_clr: assert property (p_glob_clr) else $error("global clear missed");

	property p_ccic;
		s_oci_flip |-> ##2 state_reg.ccic;
	endproperty
	a_ccic: assert property (p_ccic) else $error("change flag not set");

	property p_unknown;
		cmd_valid && !cmd_code[CMD_WRITE_BIT] && cmd_code > CMD_RD_STATUS
			|=> cmd_unknown && rsp_rdata == '0;
	endproperty
	a_unknown: assert property (p_unknown) else $error("unknown code answered");
endmodule : rhp_regs
`default_nettype wire

// ===== testbench/tb_rhp_regs.sv
`default_nettype none
module tb_rhp_regs
	import rhp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk;
	logic        rst_n;
	logic        cmd_valid;
	logic [7:0]  cmd_code;
	logic [31:0] cmd_wdata;
	logic        over_current;
	logic [1:0]  port_set_power;
	logic [1:0]  port_clear_power;
	logic        rsp_valid;
	logic [31:0] rsp_rdata;
	logic        cmd_unknown;
	logic [1:0]  port_power;
	logic        remote_wakeup_en;
	int          err_total;
	int          cmp_count;

	rhp_regs #(.NUM_PORTS(2)) rhp_regs_i
	(
		.clk              (clk),
		.rst_n            (rst_n),
		.cmd_valid        (cmd_valid),
		.cmd_code         (cmd_code),
		.cmd_wdata        (cmd_wdata),
		.over_current     (over_current),
		.port_set_power   (port_set_power),
		.port_clear_power (port_clear_power),
		.rsp_valid        (rsp_valid),
		.rsp_rdata        (rsp_rdata),
		.cmd_unknown      (cmd_unknown),
		.port_power       (port_power),
		.remote_wakeup_en (remote_wakeup_en)
	);

	// ************************************************************
	// clock and helpers
	// ************************************************************
	// free running 10 MHz clock
	always #50 clk = ~clk;

	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// compare seen against expected
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one command, answer taken one cycle later
	task automatic cmd(input logic [7:0] code, input logic [31:0] wdata, output logic [31:0] d);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code  = code;
		cmd_wdata = wdata;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_code  = 8'h00;
		cmd_wdata = ~wdata;
		check("rsp_valid", {31'h0, rsp_valid}, 32'h1);
		d = rsp_rdata;
	endtask : cmd

	// write command, answer word is zero
	task automatic wr(input logic [7:0] code, input logic [31:0] wdata);
		logic [31:0] d;
		cmd(code, wdata, d);
		check("write_rdata", d, 32'h0);
	endtask : wr

	// read command compared against expectation
	task automatic rdchk(input string name, input logic [7:0] code, input logic [31:0] exp);
		logic [31:0] d;
		cmd(code, 32'h0, d);
		check(name, d, exp);
	endtask : rdchk

	// per-port power strobes for one cycle
	task automatic strobe(input logic [1:0] set_v, input logic [1:0] clr_v);
		@(negedge clk);
		port_set_power   = set_v;
		port_clear_power = clr_v;
		@(negedge clk);
		port_set_power   = 2'h0;
		port_clear_power = 2'h0;
	endtask : strobe

	// port power one cycle on
	task automatic pwrchk(input logic [1:0] exp);
		@(negedge clk);
		check("port_power", {30'h0, port_power}, {30'h0, exp});
	endtask : pwrchk

	// ************************************************************
	// watchdog and main sequence
	// ************************************************************
	// cut a hang well beyond the hundred or so cycles needed
	initial
	begin
		repeat (3000) @(posedge clk);
		err_total++;
		stop_test();
	end

	initial
	begin
		logic [31:0] d;
		clk = 1'b0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 32'h0;
		over_current = 1'b0;
		port_set_power = 2'h0;
		port_clear_power = 2'h0;
		err_total = 0;
		cmp_count = 0;
		repeat (12) @(negedge clk);
		check("rst_rsp_valid", {31'h0, rsp_valid}, 32'h0);
		check("rst_power", {30'h0, port_power}, 32'h0);
		rst_n = 1'b1;
		rdchk("desc_a_rst", CMD_RD_DESC_A, 32'hff000902);
		rdchk("desc_b_rst", CMD_RD_DESC_B, 32'h0);
		rdchk("status_rst", CMD_RD_STATUS, 32'h0);
		// unknown code flagged, answer zero
		cmd(8'h15, 32'hffffffff, d);
		check("unknown_flag", {31'h0, cmd_unknown}, 32'h1);
		check("unknown_rdata", d, 32'h0);
		wr(CMD_WR_DESC_B, 32'hffffffff);
		rdchk("desc_b_all", CMD_RD_DESC_B, 32'h00060006);
		wr(CMD_WR_DESC_B, 32'h00020004);
		rdchk("desc_b_mix", CMD_RD_DESC_B, 32'h00020004);

		wr(CMD_WR_DESC_A, 32'hff000800);
		rdchk("desc_a_glob", CMD_RD_DESC_A, 32'hff000802);
		wr(CMD_WR_DESC_B, 32'h00060000);
		wr(CMD_WR_STATUS, 32'h00010000);
		pwrchk(2'b11);
		strobe(2'b00, 2'b11);
		pwrchk(2'b11);
		wr(CMD_WR_STATUS, 32'h00000001);
		pwrchk(2'b00);
		strobe(2'b11, 2'b00);
		pwrchk(2'b00);

		// per-port mode with port 2 masked
		wr(CMD_WR_DESC_A, 32'hff000900);
		wr(CMD_WR_DESC_B, 32'h00040000);
		wr(CMD_WR_STATUS, 32'h00010000);
		pwrchk(2'b01);
		strobe(2'b10, 2'b00);
		pwrchk(2'b11);
		wr(CMD_WR_STATUS, 32'h00000001);
		pwrchk(2'b10);
		strobe(2'b01, 2'b00);
		pwrchk(2'b10);
		strobe(2'b00, 2'b10);
		pwrchk(2'b00);

		// wake-up enable in the low half
		wr(CMD_WR_STATUS, 32'h00008000);
		check("wakeup_en", {31'h0, remote_wakeup_en}, 32'h1);
		rdchk("status_drwe", CMD_RD_STATUS, 32'h00008000);
		wr(CMD_WR_STATUS, 32'h80000000);
		rdchk("status_crwe", CMD_RD_STATUS, 32'h0);

		// overcurrent change in the high half
		wr(CMD_WR_DESC_A, 32'hff000003);
		rdchk("desc_a_cnt", CMD_RD_DESC_A, 32'hff000002);
		@(negedge clk);
		over_current = 1'b1;
		repeat (3) @(negedge clk);
		rdchk("status_oc", CMD_RD_STATUS, 32'h00020002);
		wr(CMD_WR_STATUS, 32'h00020000);
		rdchk("status_oc_clr", CMD_RD_STATUS, 32'h00000002);
		@(negedge clk);
		over_current = 1'b0;
		repeat (3) @(negedge clk);
		rdchk("status_oc_end", CMD_RD_STATUS, 32'h00020000);

		// no switching keeps all ports on
		wr(CMD_WR_DESC_A, 32'hff000a00);
		rdchk("desc_a_nps", CMD_RD_DESC_A, 32'hff000a02);
		pwrchk(2'b11);
		wr(CMD_WR_STATUS, 32'h00000001);
		pwrchk(2'b11);
		wr(CMD_WR_DESC_A, 32'hff000b00);
		strobe(2'b00, 2'b11);
		pwrchk(2'b11);
		wr(CMD_WR_STATUS, 32'h00000001);
		pwrchk(2'b11);
		stop_test();
	end
endmodule : tb_rhp_regs
`default_nettype wire
